// ==== verilog/lrsdi_consts.svh ====
`ifndef LRSDI_CONSTS_SVH
`define LRSDI_CONSTS_SVH

// ****************************************
// register addresses
// ****************************************
`define LRSDI_ADDR_CTRL0 8'h20
`define LRSDI_ADDR_CTRL1 8'h21
`define LRSDI_ADDR_STATUS 8'h24
`define LRSDI_ADDR_DATA 8'h25
`define LRSDI_ADDR_IDH 8'h26
`define LRSDI_ADDR_IDL 8'h27

// ****************************************
// receiver_status bit positions
// ****************************************
`define LRSDI_ST_DR 7
`define LRSDI_ST_ER 6
`define LRSDI_ST_CD 5
`define LRSDI_ST_ID 4
`define LRSDI_ST_OV 3
`define LRSDI_ST_EOM 2
`define LRSDI_ST_LOW_POWER_SNIFF_SELECT 1
`define LRSDI_ST_ACK 0

// ****************************************
// control register bit positions
// ****************************************
`define LRSDI_C0_IE_DR 7
`define LRSDI_C0_IE_ER 6
`define LRSDI_C0_IE_CD 5
`define LRSDI_C0_IE_ID 4
`define LRSDI_C0_PAGE 0
`define LRSDI_C1_ID_CHECK_SELECT_LO 0
`define LRSDI_C1_ID_CHECK_SELECT_HI 1
`define LRSDI_C1_CARRIER_MODE_SELECT 2
`define LRSDI_C1_TOGGLE_MODE_SELECT 3
`define LRSDI_C1_DIGITAL_DECODER_ENABLE 4
`define LRSDI_C1_VCNT_LO 5
`define LRSDI_C1_VCNT_HI 7

// ****************************************
// reset values
// ****************************************
`define LRSDI_STATUS_RST 8'h02
`define LRSDI_CTRL0_RST 8'h00
`define LRSDI_CTRL1_RST 8'h30
`define LRSDI_ID_RST 8'h00

// ****************************************
// timing
// ****************************************
`define LRSDI_CLK_MHZ 100
`define LRSDI_SNIFF_EXTRA_US 200
`define LRSDI_SNIFF_EXTRA_CYC (`LRSDI_SNIFF_EXTRA_US * `LRSDI_CLK_MHZ)

`endif

// ==== verilog/lrsdi_pkg.sv ====
package lrsdi_pkg;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lrsdi_bus_t;

    // events from the decoder front end
    typedef struct packed {
        logic bit_valid;
        logic bit_val;
        logic sync;
        logic manch_err;
        logic eom_err;
        logic id_done;
        logic carrier_valid;
        logic carrier_lost;
        logic [15:0] id;
    } lrsdi_rx_ev_t;

    typedef struct packed {
        logic dr;
        logic er;
        logic cd;
        logic idm;
        logic ov;
        logic eom;
    } lrsdi_flags_t;

    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] cnt;
        logic valid;
        logic [7:0] byte_q;
    } lrsdi_asm_st_t;

    typedef struct packed {
        logic match;
        logic reject;
    } lrsdi_idc_st_t;

    typedef struct packed {
        lrsdi_flags_t flags;
        logic low_power_sniff_select;
        logic ack;
        logic [7:0] data;
        logic [7:0] idh;
        logic [7:0] idl;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] rdata;
        logic [2:0] vcnt;
        logic stored;
        logic ignore;
        logic carrier_mode_select_prev;
        logic [14:0] sniff_cnt;
    } lrsdi_top_st_t;

endpackage

// ==== verilog/lrsdi_byte_asm.sv ====
`timescale 1ns/1ps
module lrsdi_byte_asm
    import lrsdi_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // serial bits
    input wire logic i_en,
    input wire logic i_sync,
    input wire logic i_bit_valid,
    input wire logic i_bit_val,
    // assembled byte
    output logic o_byte_valid,
    output logic [7:0] o_byte
);

    lrsdi_asm_st_t st_q;
    lrsdi_asm_st_t st_d;

    // msb first; a sync restarts the count so a partial byte never leaks out
    always_comb begin
        st_d = st_q;
        st_d.valid = 1'b0;
        if (i_sync) begin
            st_d.cnt = 3'h0;
        end else if (i_en && i_bit_valid) begin
            st_d.shift = {st_q.shift[6:0], i_bit_val};
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt == 3'h7) begin
                st_d.valid = 1'b1;
                st_d.byte_q = {st_q.shift[6:0], i_bit_val};
            end
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_byte_valid = st_q.valid;
    assign o_byte = st_q.byte_q;

endmodule // lrsdi_byte_asm

// ==== verilog/lrsdi_id_check.sv ====
`timescale 1ns/1ps
module lrsdi_id_check
    import lrsdi_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // comparison inputs
    input wire logic [1:0] i_sel,
    input wire logic [15:0] i_stored,
    input wire logic [15:0] i_rx_id,
    input wire logic i_id_done,
    // results, one-cycle pulses
    output logic o_match,
    output logic o_reject
);

    lrsdi_idc_st_t st_q;
    lrsdi_idc_st_t st_d;
    logic eq;

    // 01 low byte, 10 high byte, 11 both, 00 full word with no rejection
    always_comb begin
        unique case (i_sel)
            2'h1: eq = (i_rx_id[7:0] == i_stored[7:0]);
            2'h2: eq = (i_rx_id[15:8] == i_stored[15:8]);
            default: eq = (i_rx_id == i_stored);
        endcase
        st_d.match = i_id_done && eq;
        st_d.reject = i_id_done && !eq && (i_sel != 2'h0);
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_match = st_q.match;
    assign o_reject = st_q.reject;

endmodule // lrsdi_id_check

// ==== verilog/lrsdi_top.sv ====
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "lrsdi_consts.svh"

// How it works
// - completed byte sets byte ready bit 7
// - ack write or data read clears ready
// - enabled ready, error, id flags raise irq
// - manchester timing error sets error bit 6
// - carrier mode keeps error, overrun, eom clear
// - enough consecutive validations set carrier bit 5
// - received id equal stored sets bit 4
// - new byte over unread byte sets overrun
// - eom error after stored byte sets bit 2
// - sniff select resets high, slows transition
// - ack write one clears all six flags
// - ack bit self clears next clock edge
// - ack reads zero, reset leaves it alone
// - reset clears all six status flags
// - serial bits assembled into byte register
// - received byte register ignores writes
// - page registers only with page zero
// - sixteen bit id in two bytes
// - mismatching id message is ignored
// - reset clears both id bytes
// - carrier irq enable ignored in data mode
// - status layout fixed, reset value 0x02
module lrsdi_top
    import lrsdi_pkg::*;
#(
    parameter int SNIFF_CYC = `LRSDI_SNIFF_EXTRA_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // register port
    input wire lrsdi_bus_t i_bus,
    output logic [7:0] o_rdata,
    // decoder front end
    input wire lrsdi_rx_ev_t i_rx,
    // processor side
    output logic o_irq,
    output logic o_msg_ignored,
    // receiver controls
    output logic o_low_power_sniff,
    output logic o_data_path_ready,
    output logic o_page_sel,
    output logic [15:0] o_match_id
);

    // ****************************************
    // state and decode
    // ****************************************
    lrsdi_top_st_t st_q;
    lrsdi_top_st_t st_d;
    logic byte_valid;
    logic [7:0] byte_new;
    logic id_match;
    logic id_reject;
    logic carrier_mode_select;
    logic digital_decoder_enable;
    logic data_on;
    logic asm_en;
    logic [3:0] vnext;
    logic [2:0] vcfg;
    localparam logic [7:0] STATUS_RST = `LRSDI_STATUS_RST;

    // paged registers vanish while the page select bit is set
    function automatic logic hit(input logic [7:0] a, input logic [7:0] want,
                                 input logic page);
        logic paged;
        paged = (want != `LRSDI_ADDR_CTRL0) && (want != `LRSDI_ADDR_CTRL1);
        return (a == want) && !(paged && page);
    endfunction

    assign carrier_mode_select = st_q.ctrl1[`LRSDI_C1_CARRIER_MODE_SELECT];
    assign digital_decoder_enable = st_q.ctrl1[`LRSDI_C1_DIGITAL_DECODER_ENABLE];
    assign data_on = !carrier_mode_select && digital_decoder_enable;
    assign asm_en = data_on && !st_q.ignore;
    assign vcfg = st_q.ctrl1[`LRSDI_C1_VCNT_HI:`LRSDI_C1_VCNT_LO];
    assign vnext = {1'b0, st_q.vcnt} + 4'h1;

    // ****************************************
    // sub blocks
    // ****************************************
    // byte assembly
    lrsdi_byte_asm u_asm (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_en(asm_en),
        .i_sync(i_rx.sync),
        .i_bit_valid(i_rx.bit_valid),
        .i_bit_val(i_rx.bit_val),
        .o_byte_valid(byte_valid),
        .o_byte(byte_new)
    );

    lrsdi_id_check u_idc (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_sel(st_q.ctrl1[`LRSDI_C1_ID_CHECK_SELECT_HI:`LRSDI_C1_ID_CHECK_SELECT_LO]),
        .i_stored({st_q.idh, st_q.idl}),
        .i_rx_id(i_rx.id),
        .i_id_done(i_rx.id_done && data_on),
        .o_match(id_match),
        .o_reject(id_reject)
    );

    // ****************************************
    // next state
    // ****************************************
    // ack and data read clears are applied first so that every set below overrides them
    always_comb begin
        st_d = st_q;
        st_d.rdata = 8'h00;
        st_d.carrier_mode_select_prev = carrier_mode_select;
        // ack only lives for one cycle
        st_d.ack = i_bus.wr && hit(i_bus.addr, `LRSDI_ADDR_STATUS, o_page_sel)
                   && i_bus.wdata[`LRSDI_ST_ACK];
        // register writes
        // data register has no write path
        if (i_bus.wr) begin
            if (hit(i_bus.addr, `LRSDI_ADDR_CTRL0, o_page_sel)) begin
                st_d.ctrl0 = i_bus.wdata;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_CTRL1, o_page_sel)) begin
                st_d.ctrl1 = i_bus.wdata;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_STATUS, o_page_sel)) begin
                st_d.low_power_sniff_select = i_bus.wdata[`LRSDI_ST_LOW_POWER_SNIFF_SELECT];
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_IDH, o_page_sel)) begin
                st_d.idh = i_bus.wdata;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_IDL, o_page_sel)) begin
                st_d.idl = i_bus.wdata;
            end
        end
        if (st_q.ack) begin
            st_d.flags = '0;
        end
        if (i_bus.rd && hit(i_bus.addr, `LRSDI_ADDR_DATA, o_page_sel)) begin
            st_d.flags.dr = 1'b0;
        end
        if (byte_valid) begin
            st_d.data = byte_new;
            st_d.stored = 1'b1;
            st_d.flags.dr = 1'b1;
            if (st_q.flags.dr) begin
                st_d.flags.ov = 1'b1;
            end
        end
        if (i_rx.manch_err && data_on) begin
            st_d.flags.er = 1'b1;
        end
        // eom only after a stored byte
        if (i_rx.eom_err && data_on && st_q.stored) begin
            st_d.flags.eom = 1'b1;
        end
        if (id_match) begin
            st_d.flags.idm = 1'b1;
        end
        // drop the rest of a foreign message
        if (id_reject) begin
            st_d.ignore = 1'b1;
        end
        if (i_rx.sync) begin
            st_d.ignore = 1'b0;
            st_d.stored = 1'b0;
        end
        // consecutive validation count, off in toggle mode
        if (carrier_mode_select && !st_q.ctrl1[`LRSDI_C1_TOGGLE_MODE_SELECT]) begin
            if (i_rx.carrier_lost) begin
                st_d.vcnt = 3'h0;
            end else if (i_rx.carrier_valid) begin
                if (vnext >= {1'b0, vcfg}) begin
                    st_d.flags.cd = 1'b1;
                    st_d.vcnt = 3'h0;
                end else begin
                    st_d.vcnt = vnext[2:0];
                end
            end
        end else begin
            st_d.vcnt = 3'h0;
        end
        // unused flags held clear in carrier mode
        if (carrier_mode_select) begin
            st_d.flags.er = 1'b0;
            st_d.flags.ov = 1'b0;
            st_d.flags.eom = 1'b0;
        end
        // low power sniff costs a slower data hand-over
        if (st_q.carrier_mode_select_prev && !carrier_mode_select && st_q.low_power_sniff_select) begin
            st_d.sniff_cnt = SNIFF_CYC[14:0];
        end else if (st_q.sniff_cnt != 15'h0000) begin
            st_d.sniff_cnt = st_q.sniff_cnt - 15'h0001;
        end
        // register reads, answered one cycle later
        if (i_bus.rd) begin
            if (hit(i_bus.addr, `LRSDI_ADDR_CTRL0, o_page_sel)) begin
                st_d.rdata = st_q.ctrl0;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_CTRL1, o_page_sel)) begin
                st_d.rdata = st_q.ctrl1;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_STATUS, o_page_sel)) begin
                st_d.rdata = {st_q.flags.dr, st_q.flags.er, st_q.flags.cd,
                              st_q.flags.idm, st_q.flags.ov, st_q.flags.eom,
                              st_q.low_power_sniff_select, 1'b0};
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_DATA, o_page_sel)) begin
                st_d.rdata = st_q.data;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_IDH, o_page_sel)) begin
                st_d.rdata = st_q.idh;
            end
            if (hit(i_bus.addr, `LRSDI_ADDR_IDL, o_page_sel)) begin
                st_d.rdata = st_q.idl;
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // the ack bit keeps running under reset; a write cannot occur then anyway
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st_q <= '0;
            // flags clear, id clear, sniff set
            st_q.flags <= '0;
            st_q.low_power_sniff_select <= STATUS_RST[`LRSDI_ST_LOW_POWER_SNIFF_SELECT];
            st_q.idh <= `LRSDI_ID_RST;
            st_q.idl <= `LRSDI_ID_RST;
            st_q.ctrl0 <= `LRSDI_CTRL0_RST;
            st_q.ctrl1 <= `LRSDI_CTRL1_RST;
            st_q.ack <= st_d.ack;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // enabled flags, carrier enable gated, plain or
    assign o_irq = (st_q.flags.dr && st_q.ctrl0[`LRSDI_C0_IE_DR])
                 || (st_q.flags.er && st_q.ctrl0[`LRSDI_C0_IE_ER])
                 || (st_q.flags.idm && st_q.ctrl0[`LRSDI_C0_IE_ID])
                 || (st_q.flags.cd && st_q.ctrl0[`LRSDI_C0_IE_CD]
                     && (carrier_mode_select || !digital_decoder_enable));
    assign o_rdata = st_q.rdata;
    assign o_msg_ignored = st_q.ignore;
    assign o_low_power_sniff = st_q.low_power_sniff_select;
    // the cycle that leaves carrier mode is held off too, before the count has loaded
    assign o_data_path_ready = !carrier_mode_select && (st_q.sniff_cnt == 15'h0000)
                             && !(st_q.carrier_mode_select_prev && st_q.low_power_sniff_select);
    assign o_page_sel = st_q.ctrl0[`LRSDI_C0_PAGE];
    assign o_match_id = {st_q.idh, st_q.idl};

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_ack_write;
        i_bus.wr && (i_bus.addr == `LRSDI_ADDR_STATUS) && !o_page_sel
        && i_bus.wdata[`LRSDI_ST_ACK];
    endsequence

    sequence s_quiet;
        !byte_valid && !i_rx.manch_err && !i_rx.eom_err && !id_match
        && !i_rx.carrier_valid;
    endsequence

    a_ack_self_clear: assert property (s_ack_write ##1 !i_bus.wr |->
                                       st_q.ack ##1 !st_q.ack)
        else $error("ack bit did not self clear");
    a_ack_clears_all: assert property (s_ack_write ##1 s_quiet |=> st_q.flags == '0)
        else $error("ack did not clear the flags");
    a_ack_reads_zero: assert property (i_bus.rd && !o_page_sel
                                       && i_bus.addr == `LRSDI_ADDR_STATUS
                                       |=> !o_rdata[`LRSDI_ST_ACK])
        else $error("ack bit read back as one");
    a_byte_sets_ready: assert property (byte_valid |=>
                                        st_q.flags.dr && st_q.data == $past(byte_new))
        else $error("byte did not land with ready");
    a_read_clears_ready: assert property (i_bus.rd && i_bus.addr == `LRSDI_ADDR_DATA
                                          && !o_page_sel && !byte_valid |=> !st_q.flags.dr)
        else $error("data read left ready set");
    a_overrun_set: assert property (byte_valid && st_q.flags.dr && !carrier_mode_select
                                    |=> st_q.flags.ov)
        else $error("overrun missed");
    a_carrier_quiet: assert property (carrier_mode_select ##1 carrier_mode_select |->
                                      !st_q.flags.er && !st_q.flags.ov && !st_q.flags.eom)
        else $error("data flag set in carrier mode");
    a_data_read_only: assert property (i_bus.wr && !byte_valid |=> $stable(st_q.data))
        else $error("received byte changed by a write");
    a_set_beats_ack: assert property (st_q.ack && i_rx.manch_err && data_on
                                      |=> st_q.flags.er)
        else $error("error lost against ack");
    a_irq_drops: assert property ((st_q.ack && !i_bus.rd) and s_quiet |=> !o_irq)
        else $error("irq stayed up after clear");
    a_ready_irq: assert property (st_q.flags.dr && st_q.ctrl0[`LRSDI_C0_IE_DR] |-> o_irq)
        else $error("enabled ready gave no irq");
    // timing error raises the error flag
    a_error_sets: assert property (i_rx.manch_err && data_on |=> st_q.flags.er)
        else $error("timing error not flagged");
    // a matching id raises its flag
    a_id_sets_flag: assert property (id_match |=> st_q.flags.idm)
        else $error("id match not flagged");
    a_eom_sets: assert property (i_rx.eom_err && data_on && st_q.stored
                                 |=> st_q.flags.eom)
        else $error("end of message not flagged");
    // carrier flag cannot interrupt in data mode
    a_data_mode_irq: assert property (data_on && !st_q.flags.dr && !st_q.flags.er
                                      && !st_q.flags.idm |-> !o_irq)
        else $error("carrier flag interrupted in data mode");
    // sniff select delays the data path
    a_sniff_hold: assert property (st_q.carrier_mode_select_prev && !carrier_mode_select && st_q.low_power_sniff_select
                                   |-> !o_data_path_ready ##1 !o_data_path_ready)
        else $error("data path ready too early");
    // a rejected id marks the message ignored
    a_reject_ignores: assert property (id_reject && !i_rx.sync |=> o_msg_ignored)
        else $error("rejected id not ignored");
    // nothing of an ignored message is stored
    a_ignore_blocks: assert property (st_q.ignore |=> !byte_valid)
        else $error("byte assembled while ignored");
    // toggle mode stops the validation count
    a_toggle_no_count: assert property (st_q.ctrl1[`LRSDI_C1_TOGGLE_MODE_SELECT] |=> st_q.vcnt == 3'h0)
        else $error("validation counted in toggle mode");

endmodule // lrsdi_top

// ==== sim/lrsdi_dec_model.sv ====
`timescale 1ns/1ps
module lrsdi_dec_model
    import lrsdi_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // decoder events toward the block
    output lrsdi_rx_ev_t o_rx
);
    // ****************************************
    // event driver
    // ****************************************
    initial begin
        o_rx = '0;
    end

    // one event for one cycle; data lines then show the inverse, never a stale copy
    task automatic ev(input lrsdi_rx_ev_t e, input int gap);
        lrsdi_rx_ev_t idle;
        idle = '0;
        idle.bit_val = ~e.bit_val;
        idle.id = ~e.id;
        @(posedge i_ref_clk);
        o_rx <= e;
        @(posedge i_ref_clk);
        o_rx <= idle;
        repeat (gap) @(posedge i_ref_clk);
    endtask

    // msb first; every other bit comes slowly to vary the spacing
    task automatic send_byte(input logic [7:0] b);
        lrsdi_rx_ev_t e;
        for (int i = 7; i >= 0; i--) begin
            e = '0;
            e.bit_valid = 1'b1;
            e.bit_val = b[i];
            ev(e, i % 2);
        end
    endtask
endmodule // lrsdi_dec_model

// ==== sim/test_lf_receiver_status_data_id.sv ====
`timescale 1ns/1ps
`include "lrsdi_consts.svh"
module test_lf_receiver_status_data_id;
    import lrsdi_pkg::*;
    localparam logic [7:0] A_C0 = `LRSDI_ADDR_CTRL0;
    localparam logic [7:0] A_C1 = `LRSDI_ADDR_CTRL1;
    localparam logic [7:0] A_ST = `LRSDI_ADDR_STATUS;
    localparam logic [7:0] A_DT = `LRSDI_ADDR_DATA;
    localparam logic [7:0] A_IH = `LRSDI_ADDR_IDH;
    localparam logic [7:0] A_IL = `LRSDI_ADDR_IDL;
    logic ref_clk;
    logic rstn;
    lrsdi_bus_t bus;
    lrsdi_rx_ev_t rx;
    lrsdi_rx_ev_t e;
    logic [7:0] rdata;
    logic irq, ign, lps, dpr, pg;
    logic [15:0] mid;
    int error_cnt, samples_checked, cyc;

    // ****************************************
    // design and decoder model
    // ****************************************
    lrsdi_top #(.SNIFF_CYC(20)) lrsdi_top_inst (
        .i_ref_clk(ref_clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata), .i_rx(rx),
        .o_irq(irq), .o_msg_ignored(ign), .o_low_power_sniff(lps),
        .o_data_path_ready(dpr), .o_page_sel(pg), .o_match_id(mid)
    );
    lrsdi_dec_model lrsdi_dec_model_inst (.i_ref_clk(ref_clk), .o_rx(rx));

    // clock, and a ceiling far above the few hundred cycles the tests need
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 check(nm, {8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic pulse(input int which, input logic [15:0] id);
        e = '0;
        e.id = id;
        case (which)
            0: e.sync = 1'b1;
            1: e.manch_err = 1'b1;
            2: e.eom_err = 1'b1;
            3: e.id_done = 1'b1;
            5: e.carrier_lost = 1'b1;
            default: e.carrier_valid = 1'b1;
        endcase
        lrsdi_dec_model_inst.ev(e, 0);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rdc("status", A_ST, 8'h02);
        rdc("data", A_DT, 8'h00);
        rdc("id_high", A_IH, 8'h00);
        rdc("id_low", A_IL, 8'h00);
        rdc("unmapped", 8'h40, 8'h00);
        check("sniff", {15'h0000, lps}, 16'h0001);
        check("irq", {15'h0000, irq}, 16'h0000);
        $display("reset values done");
    endtask

    task automatic t_byte();
        pulse(0, 16'h0000);
        lrsdi_dec_model_inst.send_byte(8'hA5);
        rdc("status", A_ST, 8'h82);
        check("irq", {15'h0000, irq}, 16'h0000);
        wr(A_C0, 8'h80);
        check("irq", {15'h0000, irq}, 16'h0001);
        rdc("data", A_DT, 8'hA5);
        rdc("status", A_ST, 8'h02);
        check("irq", {15'h0000, irq}, 16'h0000);
        wr(A_C0, 8'h00);
        $display("byte receive done");
    endtask

    task automatic t_overrun();
        lrsdi_dec_model_inst.send_byte(8'h3C);
        lrsdi_dec_model_inst.send_byte(8'hC3);
        wr(A_DT, 8'h55);
        wr(A_ST, 8'h02);
        rdc("status", A_ST, 8'h8A);
        rdc("data", A_DT, 8'hC3);
        rdc("status", A_ST, 8'h0A);
        wr(A_ST, 8'h03);
        rdc("status", A_ST, 8'h02);
        rdc("status", A_ST, 8'h02);
        $display("overrun done");
    endtask

    task automatic t_errors();
        wr(A_C0, 8'h40);
        pulse(1, 16'h0000);
        rdc("status", A_ST, 8'h42);
        check("irq", {15'h0000, irq}, 16'h0001);
        wr(A_ST, 8'h03);
        @(posedge ref_clk);
        #1 check("irq", {15'h0000, irq}, 16'h0000);
        fork
            wr(A_ST, 8'h03);
            begin
                @(posedge ref_clk);
                pulse(1, 16'h0000);
            end
        join
        rdc("status", A_ST, 8'h42);
        wr(A_ST, 8'h03);
        pulse(0, 16'h0000);
        lrsdi_dec_model_inst.send_byte(8'h0F);
        pulse(2, 16'h0000);
        rdc("status", A_ST, 8'h86);
        check("irq", {15'h0000, irq}, 16'h0000);
        wr(A_ST, 8'h03);
        wr(A_C0, 8'h00);
        $display("error flags done");
    endtask

    task automatic t_id();
        wr(A_IH, 8'h12);
        wr(A_IL, 8'h34);
        rdc("id_high", A_IH, 8'h12);
        rdc("id_low", A_IL, 8'h34);
        check("match_id", mid, 16'h1234);
        wr(A_C0, 8'h10);
        pulse(3, 16'h1234);
        rdc("status", A_ST, 8'h12);
        check("irq", {15'h0000, irq}, 16'h0001);
        wr(A_ST, 8'h03);
        wr(A_C1, 8'h33);
        pulse(0, 16'h0000);
        pulse(3, 16'h1299);
        @(posedge ref_clk);
        #1 check("ignored", {15'h0000, ign}, 16'h0001);
        lrsdi_dec_model_inst.send_byte(8'h66);
        rdc("status", A_ST, 8'h02);
        pulse(0, 16'h0000);
        @(posedge ref_clk);
        #1 check("ignored", {15'h0000, ign}, 16'h0000);
        wr(A_C1, 8'h30);
        wr(A_C0, 8'h00);
        $display("id match done");
    endtask

    task automatic t_carrier();
        wr(A_C1, 8'h34);
        pulse(1, 16'h0000);
        pulse(2, 16'h0000);
        rdc("status", A_ST, 8'h02);
        pulse(4, 16'h0000);
        rdc("status", A_ST, 8'h22);
        wr(A_C0, 8'h20);
        check("irq", {15'h0000, irq}, 16'h0001);
        wr(A_C1, 8'h30);
        check("path_ready", {15'h0000, dpr}, 16'h0000);
        check("irq", {15'h0000, irq}, 16'h0000);
        wr(A_C1, 8'h20);
        check("irq", {15'h0000, irq}, 16'h0001);
        wr(A_ST, 8'h03);
        wr(A_C1, 8'h3C);
        pulse(4, 16'h0000);
        rdc("status", A_ST, 8'h02);
        wr(A_C1, 8'h54);
        pulse(4, 16'h0000);
        pulse(5, 16'h0000);
        pulse(4, 16'h0000);
        rdc("status", A_ST, 8'h02);
        pulse(4, 16'h0000);
        rdc("status", A_ST, 8'h22);
        wr(A_ST, 8'h03);
        wr(A_C1, 8'h30);
        repeat (30) @(posedge ref_clk);
        #1 check("path_ready", {15'h0000, dpr}, 16'h0001);
        wr(A_C0, 8'h00);
        $display("carrier mode done");
    endtask

    task automatic t_page();
        wr(A_C0, 8'h01);
        check("page", {15'h0000, pg}, 16'h0001);
        rdc("status", A_ST, 8'h00);
        wr(A_IL, 8'h77);
        wr(A_C0, 8'h00);
        rdc("id_low", A_IL, 8'h34);
        $display("page select done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        bus = '0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_byte();
        t_overrun();
        t_errors();
        t_id();
        t_carrier();
        t_page();
        complete_run();
    end
endmodule // test_lf_receiver_status_data_id
